// >>> src/eac_pkg.sv
// Constants and types shared by the EEPROM access control block
package eac_pkg;
  // ----------------------------------------------------------------
  // Register map (printed offsets are not word multiples: indexes)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LOCATION_POINTER = 8'h01;
  localparam logic [7:0] IDX_DATA_PORT = 8'h03;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h04;
  localparam logic [7:0] IDX_TIMER_RELOAD = 8'h05;
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h06;
  localparam logic [11:0] ADDR_LOCATION_POINTER = 12'h004;
  localparam logic [11:0] ADDR_DATA_PORT = 12'h00C;
  localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h010;
  localparam logic [11:0] ADDR_TIMER_RELOAD = 12'h014;
  localparam logic [11:0] ADDR_TIMER_COUNT = 12'h018;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_TIMER_RUN = 7;
  localparam int BIT_TIMER_IRQ_ENABLE = 6;
  localparam int BIT_TIMER_UNDERFLOW_FLAG = 5;
  localparam int BIT_ERASE_WRITE_IN_PROGRESS = 4;
  localparam int BIT_MODE_HIGH = 3;
  localparam int BIT_MODE_LOW = 1;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFE;
  localparam logic [7:0] POINTER_MASK = 8'h7F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Array geometry and timer prescaler
  // ----------------------------------------------------------------
  localparam int ARRAY_BYTES = 128;
  localparam int LATCH_COUNT = 4;
  localparam logic [1:0] LAST_LATCH = 2'h3;
  localparam logic [7:0] PRESCALE_LAST = 8'hFF;

  // ----------------------------------------------------------------
  // Mode decode of progress bit and mode bits
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_READ_BYTE = 4'h0,
    MODE_INCREMENT = 4'h2,
    MODE_WRITE_PAGE = 4'hA,
    MODE_WRITE_PAGE_ALT = 4'hB,
    MODE_ERASE_WRITE = 4'hC,
    MODE_ERASE_PAGE = 4'hF
  } eac_mode_type;

  // Gray-coded cycle sequence
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ERASE = 2'b01,
    CYC_WRITE = 2'b11
  } eac_cycle_type;
endpackage

// >>> src/eac_timer.sv
// Countdown timer with reload and underflow pulse
`timescale 1ns/10ps
`default_nettype none
module eac_timer
  import eac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [7:0] reload_value,
  // Status
  output logic [7:0] count,
  output logic underflow
);
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] prescale;
    logic underflow;
  } eac_timer_state_type;

  eac_timer_state_type state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    state_next.underflow = 1'b0;
    if (restart) begin
      state_next.count = reload_value;
      state_next.prescale = PRESCALE_RESET;
    end else if (run) begin
      // Prescaler stretches one tick to 256 clocks
      state_next.prescale = state_reg.prescale + 8'h01;
      if (state_reg.prescale == PRESCALE_LAST) begin
        if (state_reg.count == 8'h00) begin
          state_next.count = reload_value;
          state_next.underflow = 1'b1;
        end else begin
          state_next.count = state_reg.count - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= '{COUNT_RESET, PRESCALE_RESET, 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;
  assign underflow = state_reg.underflow;
endmodule
`default_nettype wire

// >>> src/eac_array.sv
// Flip-flop model of the EEPROM array with page erase and OR write
`timescale 1ns/10ps
`default_nettype none
module eac_array
  import eac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Read port
  input wire logic [6:0] read_index,
  output logic [7:0] read_data,
  // Page operation
  input wire logic [4:0] page,
  input wire logic erase_pulse,
  input wire logic write_pulse,
  input wire logic [3:0] byte_select,
  input wire logic [31:0] latch_data
);
  typedef struct packed {
    logic [ARRAY_BYTES-1:0][7:0] mem;
  } eac_array_state_type;

  eac_array_state_type state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < LATCH_COUNT; i++) begin
      if (byte_select[i]) begin
        if (erase_pulse) begin
          state_next.mem[{page, 2'(i)}] = ERASED_BYTE;
        end
        // OR write: bits only ever go to one
        if (write_pulse) begin
          state_next.mem[{page, 2'(i)}] =
            state_reg.mem[{page, 2'(i)}] | latch_data[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign read_data = state_reg.mem[read_index];
endmodule
`default_nettype wire

// >>> src/eac_top.sv
// EEPROM access control: APB registers, page latches, cycle sequencer
//
// Overview of operation
// - Control register at 04H, fields 7..1
// - Timer runs only while run bit set
// - Interrupt request only when enable set
// - Underflow or software sets flag; software clears
// - Setting progress bit starts cycle and timer
// - Unused control bit0, pointer bit7 read zero
// - Progress plus mode bits decode access mode
// - Pointer at 01H increments after read, write
// - Pointer wraps to zero past maximum
// - Pointer bits 6..2 select page
// - Bits 1..0 pick read byte, not page cycle bytes
// - Setup: bits 1..0 select latch
// - Increment mode advances subcounter, stops at 3
// - Data port at 03H reads array byte
// - Data port write loads selected latch
// - Latch write sets flag, ORs; cycle end clears
// - Page cycles touch only flagged bytes
// - Erase, write 5 ms; erase/write 10 ms
`timescale 1ns/10ps
`default_nettype none
module eac_top
  import eac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer interrupt request
  output logic timer_irq
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] pointer;
    logic [7:0] reload;
    logic [31:0] latches;
    logic [3:0] byte_select_flags;
    eac_cycle_type cycle;
    logic [31:0] rdata;
    logic slverr;
    logic irq;
  } eac_state_type;

  eac_state_type state_reg, state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] mode_code(input logic [7:0] ctrl);
    mode_code = {ctrl[BIT_ERASE_WRITE_IN_PROGRESS],
                 ctrl[BIT_MODE_HIGH:BIT_MODE_LOW]};
  endfunction

  function automatic logic [31:0] widen(input logic [7:0] v);
    widen = {24'h000000, v};
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  logic [7:0] timer_count;
  logic timer_underflow;
  logic timer_restart;
  logic [7:0] array_read;
  logic erase_pulse;
  logic write_pulse;

  eac_timer u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(state_reg.control[BIT_TIMER_RUN]),
    .restart(timer_restart),
    .reload_value(state_reg.reload),
    .count(timer_count),
    .underflow(timer_underflow)
  );

  eac_array u_array (
    .ref_clk(ref_clk),
    .reset(reset),
    .read_index(state_reg.pointer[6:0]),
    .read_data(array_read),
    .page(state_reg.pointer[6:2]),
    .erase_pulse(erase_pulse),
    .write_pulse(write_pulse),
    .byte_select(state_reg.byte_select_flags),
    .latch_data(state_reg.latches)
  );

  // ----------------------------------------------------------------
  // Register access and cycle sequencing
  // ----------------------------------------------------------------
  logic access;
  logic wr_access;
  logic rd_access;
  logic start_cycle;
  logic [7:0] wbyte;
  logic [3:0] new_mode;
  logic [1:0] sub;

  assign access = psel & penable;
  assign wr_access = access & pwrite & pstrb[0];
  assign rd_access = access & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign new_mode = mode_code(wbyte);
  assign sub = state_reg.pointer[1:0];

  // Progress bit going 0 to 1 by software write starts a cycle
  assign start_cycle = wr_access && paddr == ADDR_TIMER_CONTROL &&
    wbyte[BIT_ERASE_WRITE_IN_PROGRESS] &&
    !state_reg.control[BIT_ERASE_WRITE_IN_PROGRESS];
  assign timer_restart = start_cycle;

  // Erase or write is applied at the underflow closing its phase
  assign erase_pulse = timer_underflow && state_reg.cycle == CYC_ERASE;
  assign write_pulse = timer_underflow && state_reg.cycle == CYC_WRITE;

  always_comb begin
    state_next = state_reg;
    state_next.slverr = 1'b0;
    state_next.rdata = 32'h00000000;

    // Underflow or software sets flag; set wins over a clearing write
    if (wr_access && paddr == ADDR_TIMER_CONTROL) begin
      state_next.control = wbyte & CONTROL_WRITE_MASK;
      if (state_reg.control[BIT_ERASE_WRITE_IN_PROGRESS]) begin
        // Hardware owns the progress bit once set
        state_next.control[BIT_ERASE_WRITE_IN_PROGRESS] = 1'b1;
      end
      if (start_cycle) begin
        // A started cycle needs a running timer to ever finish
        state_next.control[BIT_TIMER_RUN] = 1'b1;
      end
    end
    if (timer_underflow) begin
      state_next.control[BIT_TIMER_UNDERFLOW_FLAG] = 1'b1;
    end

    // Location pointer write
    if (wr_access && paddr == ADDR_LOCATION_POINTER) begin
      state_next.pointer = wbyte & POINTER_MASK;
    end

    // Data port write presets a latch, ORing into it
    if (wr_access && paddr == ADDR_DATA_PORT) begin
      state_next.latches[sub*8 +: 8] =
        state_reg.latches[sub*8 +: 8] | wbyte;
      state_next.byte_select_flags[sub] = 1'b1;
      if (mode_code(state_reg.control) == MODE_INCREMENT &&
          sub != LAST_LATCH) begin
        state_next.pointer[1:0] = sub + 2'h1;
      end
    end

    // Data port read: array byte, then pointer advances with wrap
    if (rd_access && paddr == ADDR_DATA_PORT) begin
      state_next.pointer = (state_reg.pointer + 8'h01) & POINTER_MASK;
    end

    // Cycle sequencer
    case (state_reg.cycle)
      CYC_IDLE: begin
        if (start_cycle) begin
          case (new_mode)
            MODE_ERASE_WRITE, MODE_ERASE_PAGE: begin
              state_next.cycle = CYC_ERASE;
            end
            MODE_WRITE_PAGE, MODE_WRITE_PAGE_ALT: begin
              state_next.cycle = CYC_WRITE;
            end
            default: begin
              // Undefined codes end at the first underflow with no array change; the pointer still advances
              state_next.cycle = CYC_WRITE;
              state_next.byte_select_flags = 4'h0;
            end
          endcase
        end
      end
      CYC_ERASE: begin
        if (timer_underflow) begin
          if (mode_code(state_reg.control) == MODE_ERASE_WRITE) begin
            state_next.cycle = CYC_WRITE;
          end else begin
            // Erase leaves the pointer fixed
            state_next.cycle = CYC_IDLE;
            state_next.control[BIT_ERASE_WRITE_IN_PROGRESS] = 1'b0;
            state_next.latches = 32'h00000000;
            state_next.byte_select_flags = 4'h0;
          end
        end
      end
      CYC_WRITE: begin
        if (timer_underflow) begin
          state_next.cycle = CYC_IDLE;
          state_next.control[BIT_ERASE_WRITE_IN_PROGRESS] = 1'b0;
          state_next.latches = 32'h00000000;
          state_next.byte_select_flags = 4'h0;
          state_next.pointer =
            (state_reg.pointer + 8'h01) & POINTER_MASK;
        end
      end
      default: begin
        state_next.cycle = CYC_IDLE;
      end
    endcase

    // Read data and error answer
    if (rd_access) begin
      case (paddr)
        ADDR_TIMER_CONTROL: state_next.rdata = widen(state_reg.control);
        ADDR_LOCATION_POINTER: state_next.rdata = widen(state_reg.pointer);
        ADDR_DATA_PORT: state_next.rdata = widen(array_read);
        ADDR_TIMER_RELOAD: state_next.rdata = widen(state_reg.reload);
        ADDR_TIMER_COUNT: state_next.rdata = widen(timer_count);
        default: state_next.slverr = 1'b1;
      endcase
    end
    if (wr_access && paddr == ADDR_TIMER_RELOAD) begin
      state_next.reload = wbyte;
    end
    if (access && pwrite) begin
      case (paddr)
        ADDR_TIMER_CONTROL, ADDR_LOCATION_POINTER, ADDR_DATA_PORT,
        ADDR_TIMER_RELOAD: state_next.slverr = 1'b0;
        default: state_next.slverr = 1'b1;
      endcase
    end

    // Level request while flag and enable are both set
    state_next.irq = state_next.control[BIT_TIMER_UNDERFLOW_FLAG] &
      state_next.control[BIT_TIMER_IRQ_ENABLE];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg.control <= CONTROL_RESET;
      state_reg.pointer <= POINTER_RESET;
      state_reg.reload <= RELOAD_RESET;
      state_reg.latches <= 32'h00000000;
      state_reg.byte_select_flags <= 4'h0;
      state_reg.cycle <= CYC_IDLE;
      state_reg.rdata <= 32'h00000000;
      state_reg.slverr <= 1'b0;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Read data is sampled combinationally so the single-cycle access holds
  assign pready = 1'b1;
  assign prdata = rd_access ? state_next.rdata : 32'h00000000;
  assign pslverr = access ? state_next.slverr : 1'b0;
  assign timer_irq = state_reg.irq;
endmodule
`default_nettype wire

// >>> verification/eac_apb_master.sv
// APB master model standing in for the microcontroller core
`timescale 1ns/10ps
`default_nettype none
module eac_apb_master (
  // Clock
  input wire logic ref_clk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
  end

  // ------------------------------------------------------------
  // One transfer; only mapped or deliberately unmapped holes
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like the last value
    pwdata <= ~pwdata;
  endtask
endmodule
`default_nettype wire

// >>> verification/eac_checker_asserts.sv
// Port-level assertions for the EEPROM access control block
`timescale 1ns/10ps
`default_nettype none
module eac_checker
  import eac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt
  input wire logic timer_irq
);
  logic acc;
  logic rd_ctl;
  logic mapped;
  logic ctl_wr;
  assign acc = psel && penable;
  assign rd_ctl = acc && !pwrite && paddr == ADDR_TIMER_CONTROL;
  assign mapped = paddr inside {ADDR_LOCATION_POINTER, ADDR_DATA_PORT,
    ADDR_TIMER_CONTROL, ADDR_TIMER_RELOAD, ADDR_TIMER_COUNT};
  assign ctl_wr = acc && pwrite && pstrb[0] && paddr == ADDR_TIMER_CONTROL;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_idle_bus_quiet: assert property (!acc |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  a_unmapped_error: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (acc && mapped && !(pwrite &&
    paddr == ADDR_TIMER_COUNT) |-> !pslverr) else $error("mapped refused");
  a_ctl_bit0_zero: assert property (rd_ctl |-> prdata[0] == 1'b0)
    else $error("control bit 0 not zero");
  a_ptr_bit7_zero: assert property (acc && !pwrite &&
    paddr == ADDR_LOCATION_POINTER |-> !prdata[7]) else $error("ptr bit 7");
  a_upper_bits_zero: assert property (acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_irq_off_after: assert property (ctl_wr && !pwdata[6] |-> ##2 !timer_irq)
    else $error("irq still high after enable cleared");
  a_irq_needs_enable: assert property (rd_ctl && !prdata[6] |-> !timer_irq)
    else $error("irq high while enable reads zero");
  a_irq_drop_cause: assert property ($fell(timer_irq) |->
    $past(ctl_wr) || $past(reset)) else $error("irq fell with no write");
  a_ready_in_access: assert property (acc |-> pready)
    else $error("access not answered at once");
endmodule
bind eac_top eac_checker u_checker (.*);
`default_nettype wire

// >>> verification/tb_eac_top.sv
// Self-checking testbench for the EEPROM access control block
`timescale 1ns/10ps
`default_nettype none
module tb_eac_top
  import eac_pkg::*;
;
  logic ref_clk;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, timer_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] d [4];
  logic [7:0] q;
  logic e;
  logic [6:0] pg;

  eac_top uut (
    .ref_clk(ref_clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timer_irq(timer_irq)
  );
  eac_apb_master m (
    .ref_clk(ref_clk),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ------------------------------------------------------------
  // Bus tasks and comparisons
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    m.xfer(1'b1, a, v, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input string n);
    m.xfer(1'b0, a, 8'h00, q, e);
    chk(n, x, q);
  endtask
  // Software polls the progress bit before touching anything else
  task automatic wait_done(input int lo);
    int t0;
    t0 = cyc;
    q = 8'h10;
    while (q[4] === 1'b1) m.xfer(1'b0, ADDR_TIMER_CONTROL, 8'h00, q, e);
    chk("cycle len", 8'h01, {7'h0, cyc - t0 >= lo && cyc - t0 < lo + 20});
    chk("end flag", 8'h01, {7'h0, q[5]});
  endtask
  task automatic page_chk();
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_LOCATION_POINTER, {1'b0, pg});
    for (int i = 0; i < 4; i++) rd(ADDR_DATA_PORT, d[i], "page byte");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hB453));
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(ADDR_TIMER_CONTROL, CONTROL_RESET, "ctl reset");
    rd(ADDR_LOCATION_POINTER, POINTER_RESET, "ptr reset");
    wr(ADDR_TIMER_CONTROL, 8'hE5);
    rd(ADDR_TIMER_CONTROL, 8'hE4, "ctl rw");
    chk("irq on", 8'h01, {7'h0, timer_irq});
    wr(ADDR_TIMER_CONTROL, 8'hA4);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", 8'h00, {7'h0, timer_irq});
    wr(ADDR_TIMER_CONTROL, 8'h04);
    rd(ADDR_TIMER_CONTROL, 8'h04, "flag clear");
    m.xfer(1'b0, ADDR_TIMER_COUNT, 8'h00, d[0], e);
    repeat (300) @(posedge ref_clk);
    rd(ADDR_TIMER_COUNT, d[0], "timer held");
    m.xfer(1'b0, 12'h008, 8'h00, q, e);
    chk("unmapped", 8'h01, {7'h0, e});
    wr(ADDR_TIMER_RELOAD, 8'h00);
    // Random page, latches 1..3 loaded, then OR onto the last one
    pg = 7'($urandom_range(31)) << 2;
    for (int i = 0; i < 4; i++) d[i] = 8'($urandom_range(255));
    wr(ADDR_LOCATION_POINTER, {1'b0, pg + 7'h01});
    for (int i = 1; i < 4; i++) wr(ADDR_DATA_PORT, d[i]);
    wr(ADDR_DATA_PORT, d[0]);
    rd(ADDR_LOCATION_POINTER, {1'b0, pg + 7'h03}, "latch stop");
    wr(ADDR_TIMER_CONTROL, 8'h18);
    wait_done(512);
    rd(ADDR_LOCATION_POINTER, {1'b0, pg + 7'h04}, "ptr after ew");
    d[3] = d[3] | d[0];
    d[0] = 8'h00;
    page_chk();
    // Erase one byte with all-ones latch data, then write another
    wr(ADDR_LOCATION_POINTER, {1'b0, pg + 7'h02});
    wr(ADDR_DATA_PORT, 8'hFF);
    wr(ADDR_TIMER_CONTROL, 8'h1E);
    wait_done(256);
    rd(ADDR_LOCATION_POINTER, {1'b0, pg + 7'h02}, "ptr after erase");
    wr(ADDR_LOCATION_POINTER, {1'b0, pg + 7'h01});
    wr(ADDR_DATA_PORT, 8'h81);
    wr(ADDR_TIMER_CONTROL, 8'h16);
    wait_done(256);
    rd(ADDR_LOCATION_POINTER, {1'b0, pg + 7'h02}, "ptr after wp");
    d[1] = d[1] | 8'h81;
    d[2] = 8'h00;
    page_chk();
    wr(ADDR_LOCATION_POINTER, 8'h7F);
    m.xfer(1'b0, ADDR_DATA_PORT, 8'h00, q, e);
    rd(ADDR_LOCATION_POINTER, 8'h00, "ptr wrap");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
